// >>> bmc_pkg.sv
package bmc_pkg;

    // ****************************************
    // Timebase
    // ****************************************
    localparam int CLK_HZ = 100_000_000;
    localparam int TICK_US = 1000;
    localparam int TICK_CYCLES = (CLK_HZ / 1_000_000) * TICK_US;

    // ****************************************
    // Self-test timing in milliseconds
    // ****************************************
    localparam int ST_FAST_MS = 50;
    localparam int ST_DEGLITCH_MS = 100;
    localparam int ST_LONG_MS = 700;
    localparam int WIN_FAST_MS = 20;
    localparam int WIN_LONG_MS = 120;
    localparam int RESULT_HOLD_MS = 1;
    localparam int RECOVERY_MS = 2;

    localparam logic [2:0] DEGLITCH_NONE = 3'h0;
    localparam logic [2:0] ALARM_RESET = 3'h0;

    typedef enum logic [1:0] {
        BMC_IDLE,
        BMC_RUN,
        BMC_DONE,
        BMC_HOLD
    } bmc_state_t;

endpackage

// >>> bmc_sync.sv
`timescale 1ns/100ps
`default_nettype none
module bmc_sync #(
    parameter int WIDTH = 1
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta;

    // ****************************************
    // Two-stage synchroniser
    // ****************************************
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            meta <= '0;
            q <= '0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule
`default_nettype wire

// >>> bmc_tick.sv
`timescale 1ns/100ps
`default_nettype none
module bmc_tick #(
    parameter int CYCLES = 100000
) (
    input wire logic ref_clk,
    input wire logic rst,
    output logic tick
);
    logic [31:0] count;

    // ****************************************
    // Millisecond enable divider
    // ****************************************
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            count <= 32'h0;
            tick <= 1'b0;
        end else if (count == 32'(CYCLES - 1)) begin
            count <= 32'h0;
            tick <= 1'b1;
        end else begin
            count <= count + 32'h1;
            tick <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// >>> bmc_monitor.sv
// Summary of operation
// - Enable low forces standby, outputs off
// - Enable high resumes normal operation
// - Enable forwarded up the chain
// - Alarm outputs: low none, high alarm
// - Alarm status passed down chain
// - Shared mode drives three outputs alike
// - Test start forces every alarm high
// - Pass goes low, fail stays high
// - Zero deglitch gives short test
// - Nonzero deglitch gives long test
// - Test pulse relayed up, starts locally
// - Pass waits for pass from above
// - Any failure keeps its bottom output high, all three in shared mode
// - Alarm within 20 ms fails test
// - Alarm within 120 ms fails long test
// - Separate mode results per condition
// - Result held after pulse falling edge
// - Alarms valid again after result hold, new test only after recovery
`timescale 1ns/100ps
`default_nettype none
module bmc_monitor
    import bmc_pkg::*;
#(
    parameter int TICK_LEN = TICK_CYCLES,
    parameter int ST_FAST = ST_FAST_MS,
    parameter int ST_LONG = ST_LONG_MS,
    parameter int WIN_FAST = WIN_FAST_MS,
    parameter int WIN_LONG = WIN_LONG_MS,
    parameter int HOLD_T = RESULT_HOLD_MS,
    parameter int RECOV_T = RECOVERY_MS
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic enable_in,
    input wire logic test_in,
    input wire logic [2:0] deglitch_select,
    input wire logic alarm_share_select,
    input wire logic top_designation,
    input wire logic bottom_designation,
    input wire logic [2:0] cell_alarm,
    input wire logic [2:0] current_alarm_inputs,
    input wire logic [2:0] selftest_fault,
    output logic chain_enable_out,
    output logic chain_test_out,
    output logic standby,
    output logic [2:0] voltage_alarm_outputs,
    output logic [2:0] current_alarm_outputs
);
    logic [9:0] s_in;
    logic en_s;
    logic test_s;
    logic test_d;
    logic [2:0] dg_s;
    logic share_s;
    logic top_s;
    logic [2:0] alarm_s;
    logic [2:0] above_s;
    logic [2:0] fault_s;
    logic tick;
    bmc_state_t state;
    logic [15:0] timer;
    logic [15:0] since_alarm [3];
    logic [2:0] fail;
    logic [2:0] local_alarm;
    logic [2:0] status;
    logic [2:0] chain_alarm;
    logic rise;
    logic fall;
    logic long_mode;
    logic [15:0] st_len;
    logic [15:0] win_len;

    // ****************************************
    // Input synchronisation and timebase
    // ****************************************
    // Synchronise all pins but bottom_designation
    bmc_sync #(
        .WIDTH(10)
    ) u_sync (
        .ref_clk(ref_clk),
        .rst(rst),
        .d({enable_in, test_in, deglitch_select, alarm_share_select,
            top_designation, cell_alarm[0], cell_alarm[1], cell_alarm[2]}),
        .q(s_in)
    );

    bmc_sync #(
        .WIDTH(6)
    ) u_sync_chain (
        .ref_clk(ref_clk),
        .rst(rst),
        .d({current_alarm_inputs, selftest_fault}),
        .q({above_s, fault_s})
    );

    assign en_s = s_in[9];
    assign test_s = s_in[8];
    assign dg_s = s_in[7:5];
    assign share_s = s_in[4];
    assign top_s = s_in[3];
    assign alarm_s = {s_in[0], s_in[1], s_in[2]};

    bmc_tick #(
        .CYCLES(TICK_LEN)
    ) u_tick (
        .ref_clk(ref_clk),
        .rst(rst),
        .tick(tick)
    );

    function automatic logic [15:0] ms(input int v);
        ms = 16'(v);
    endfunction

    assign long_mode = (dg_s != DEGLITCH_NONE);
    assign st_len = long_mode ? ms(ST_LONG) : ms(ST_FAST);
    assign win_len = long_mode ? ms(WIN_LONG) : ms(WIN_FAST);

    // ****************************************
    // Edge detection
    // ****************************************
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            test_d <= 1'b0;
        end else begin
            test_d <= test_s & en_s;
        end
    end

    assign rise = test_s & en_s & ~test_d;
    assign fall = ~test_s & test_d;

    // ****************************************
    // Alarm age counters
    // ****************************************
    // Each counter saturates so an old alarm never looks recent.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 3; i++) begin
                since_alarm[i] <= 16'hffff;
            end
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (alarm_s[i]) begin
                    since_alarm[i] <= 16'h0;
                end else if (tick && since_alarm[i] != 16'hffff) begin
                    since_alarm[i] <= since_alarm[i] + 16'h1;
                end
            end
        end
    end

    // ****************************************
    // Self-test sequencer
    // ****************************************
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state <= BMC_IDLE;
            timer <= 16'h0;
        end else if (!en_s) begin
            state <= BMC_IDLE;
            timer <= 16'h0;
        end else begin
            unique case (state)
                BMC_IDLE: begin
                    if (rise) begin
                        state <= BMC_RUN;
                        timer <= 16'h0;
                    end
                end
                BMC_RUN: begin
                    if (fall) begin
                        state <= BMC_HOLD;
                        timer <= 16'h0;
                    end else if (tick) begin
                        if (timer + 16'h1 >= st_len) begin
                            state <= BMC_DONE;
                        end
                        timer <= timer + 16'h1;
                    end
                end
                BMC_DONE: begin
                    if (fall) begin
                        state <= BMC_HOLD;
                        timer <= 16'h0;
                    end
                end
                BMC_HOLD: begin
                    if (tick) begin
                        if (timer + 16'h1 >= ms(HOLD_T + RECOV_T)) begin
                            state <= BMC_IDLE;
                        end
                        timer <= timer + 16'h1;
                    end
                end
            endcase
        end
    end

    // ****************************************
    // Failure capture
    // ****************************************
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            fail <= ALARM_RESET;
        end else if (state == BMC_IDLE && rise) begin
            for (int i = 0; i < 3; i++) begin
                fail[i] <= alarm_s[i] || since_alarm[i] < win_len || fault_s[i];
            end
        end else if (state == BMC_RUN) begin
            for (int i = 0; i < 3; i++) begin
                if ((alarm_s[i] && timer < win_len) || fault_s[i]) begin
                    fail[i] <= 1'b1;
                end
            end
        end
    end

    // ****************************************
    // Output composition
    // ****************************************
    // Per-condition results in separate mode
    assign local_alarm = share_s ? alarm_s : {3{|alarm_s}};

    always_comb begin
        status = local_alarm | above_s;
        unique case (state)
            BMC_RUN: status = 3'h7;
            BMC_DONE, BMC_HOLD: begin
                if (timer < ms(HOLD_T) || state == BMC_DONE) begin
                    // Pass low only, after chain pass
                    status = fail | (top_s ? 3'h0 : above_s);
                end
            end
            default: status = status;
        endcase
    end

    assign chain_alarm = share_s ? status : {3{|status}};

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            voltage_alarm_outputs <= ALARM_RESET;
            current_alarm_outputs <= ALARM_RESET;
            chain_enable_out <= 1'b0;
            chain_test_out <= 1'b0;
            standby <= 1'b1;
        end else begin
            voltage_alarm_outputs <= en_s ? chain_alarm : ALARM_RESET;
            current_alarm_outputs <= en_s ? chain_alarm : ALARM_RESET;
            chain_enable_out <= en_s;
            chain_test_out <= test_s & en_s;
            standby <= ~en_s;
        end
    end
endmodule
`default_nettype wire

// >>> bmc_check_sva.sv
`timescale 1ns/100ps
`default_nettype none
module bmc_check
    import bmc_pkg::*;
#(
    parameter int TICK_LEN = 4,
    parameter int ST_FAST = 6
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic enable_in,
    input wire logic test_in,
    input wire logic alarm_share_select,
    input wire logic chain_enable_out,
    input wire logic chain_test_out,
    input wire logic standby,
    input wire logic [2:0] voltage_alarm_outputs,
    input wire logic [2:0] current_alarm_outputs
);
    // ****
    // Cycles since the test relay rose; a shortened test shows as a drop below this.
    // ****
    localparam int MIN_HI = (ST_FAST - 1) * TICK_LEN;
    int unsigned run_cnt;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            run_cnt <= 0;
        end else begin
            run_cnt <= chain_test_out ? run_cnt + 1 : 0;
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    standby_entry_a: assert property ($fell(enable_in) |-> ##3 (standby && !chain_enable_out))
        else $error("Standby not entered.");
    wake_relay_a: assert property ($rose(enable_in) |-> ##3 (!standby && chain_enable_out))
        else $error("Wake or relay missing.");
    standby_quiet_a: assert property (standby |-> (voltage_alarm_outputs == 3'h0 && !chain_test_out))
        else $error("Outputs active in standby.");
    chain_mirror_a: assert property (current_alarm_outputs == voltage_alarm_outputs)
        else $error("Chain alarm differs.");
    shared_alike_a: assert property (!alarm_share_select [*5] |-> voltage_alarm_outputs inside {3'h0, 3'h7})
        else $error("Shared outputs differ.");
    test_start_a: assert property ($rose(test_in) && !chain_test_out && !standby |-> ##3 chain_test_out ##1 (voltage_alarm_outputs == 3'h7))
        else $error("Test start missed.");
    test_high_a: assert property (chain_test_out && run_cnt >= 1 && run_cnt < MIN_HI |-> voltage_alarm_outputs == 3'h7)
        else $error("Test ended too soon.");
    relay_drop_a: assert property ($fell(test_in) && chain_test_out |-> ##3 !chain_test_out)
        else $error("Test relay stuck.");
    hold_result_a: assert property ($fell(test_in) && chain_test_out |-> ##1 $stable(voltage_alarm_outputs) [*3])
        else $error("Result not held.");
endmodule
bind bmc_monitor bmc_check #(.TICK_LEN(TICK_LEN), .ST_FAST(ST_FAST)) chk (
    .ref_clk(ref_clk), .rst(rst), .enable_in(enable_in), .test_in(test_in),
    .alarm_share_select(alarm_share_select), .chain_enable_out(chain_enable_out),
    .chain_test_out(chain_test_out), .standby(standby),
    .voltage_alarm_outputs(voltage_alarm_outputs), .current_alarm_outputs(current_alarm_outputs)
);
`default_nettype wire

// >>> bmc_upper.sv
`timescale 1ns/100ps
`default_nettype none
module bmc_upper (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic test_seen,
    input wire logic pass,
    input wire logic [15:0] pass_after,
    output logic [2:0] status
);
    // ****
    // Part above; it keeps its result a few cycles so the hold phase stays valid.
    // ****
    logic [15:0] cnt;
    logic [2:0] linger;
    logic busy;
    assign busy = test_seen || linger != 3'h0;
    // Own test runs while the relayed pulse is seen.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cnt <= 16'h0;
            linger <= 3'h0;
        end else begin
            cnt <= busy ? cnt + 16'h1 : 16'h0;
            linger <= test_seen ? 3'h7 : linger - {2'h0, linger != 3'h0};
        end
    end
    // Status goes down, high until a pass.
    assign status = (busy && (cnt < pass_after || !pass)) ? 3'h7 : 3'h0;
endmodule
`default_nettype wire

// >>> test_battery_monitor_enable_selftest_chain.sv
`timescale 1ns/100ps
`default_nettype none
module test_battery_monitor_enable_selftest_chain;
    import bmc_pkg::*;
    // ****
    // Bench
    // ****
    localparam int TK = 4;
    localparam int STF = 6;
    localparam int STL = 15;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic enable_in = 1'b1;
    logic test_in = 1'b0;
    logic [2:0] deglitch_select = 3'h0;
    logic alarm_share_select = 1'b0;
    logic top_designation = 1'b1;
    logic [2:0] cell_alarm = 3'h0;
    logic [2:0] selftest_fault = 3'h0;
    logic up_pass = 1'b1;
    logic [15:0] pass_after = 16'h8;
    logic [2:0] above;
    logic chain_enable_out;
    logic chain_test_out;
    logic standby;
    logic [2:0] voltage_alarm_outputs;
    logic [2:0] current_alarm_outputs;
    logic [5:0] exp_q[$];
    logic [31:0] seed = 32'h4645;
    logic [31:0] r;
    int fail_count = 0;
    int n_compared = 0;
    int el;
    event note_ev;
    always #5 ref_clk = ~ref_clk;
    bmc_monitor #(.TICK_LEN(TK), .ST_FAST(STF), .ST_LONG(STL), .WIN_FAST(2), .WIN_LONG(3),
        .HOLD_T(1), .RECOV_T(2)) uut (
        .ref_clk(ref_clk), .rst(rst), .enable_in(enable_in), .test_in(test_in),
        .deglitch_select(deglitch_select), .alarm_share_select(alarm_share_select),
        .top_designation(top_designation), .bottom_designation(1'b1),
        .cell_alarm(cell_alarm), .current_alarm_inputs(above), .selftest_fault(selftest_fault),
        .chain_enable_out(chain_enable_out), .chain_test_out(chain_test_out),
        .standby(standby), .voltage_alarm_outputs(voltage_alarm_outputs),
        .current_alarm_outputs(current_alarm_outputs)
    );
    bmc_upper up (.ref_clk(ref_clk), .rst(rst), .test_seen(chain_test_out), .pass(up_pass),
        .pass_after(pass_after), .status(above));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic check(input logic [5:0] seen, input logic [5:0] want);
        n_compared++;
        if (seen !== want) begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    task automatic summarize();
        if (fail_count == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    always @(note_ev) begin
        check({standby, chain_enable_out, chain_test_out, voltage_alarm_outputs}, exp_q.pop_front());
    end
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic go(input int t);
        step(t - el);
        el = t;
    endtask
    task automatic note(input logic [5:0] e);
        exp_q.push_back(e);
        -> note_ev;
    endtask
    task automatic run_test(input logic [2:0] dg, input logic top, input logic ok,
            input logic share, input logic [2:0] flt, input int gl, input logic late,
            input logic [2:0] res);
        int st;
        st = (dg == 3'h0) ? STF : STL;
        deglitch_select = dg;
        top_designation = top;
        up_pass = ok;
        alarm_share_select = share;
        selftest_fault = flt;
        pass_after = late ? 16'((st + 4) * TK) : 16'(rnd() % (st * TK));
        step(4 * TK + 8);
        // Pulse held past the test time.
        test_in = 1'b1;
        el = 0;
        go(4);
        note(6'h1f);
        if (gl > 0) begin
            go(gl);
            cell_alarm = 3'h1;
            go(gl + 3);
            cell_alarm = 3'h0;
        end
        go((st - 2) * TK);
        note(6'h1f);
        go((st + 2) * TK);
        note({3'h3, late ? 3'h7 : res});
        go((st + 6) * TK);
        note({3'h3, res});
        test_in = 1'b0;
        step(3);
        note({3'h2, res});
        step(5 * TK);
        note(6'h10);
    endtask
    initial begin
        step(20000);
        fail_count++;
        summarize();
    end
    initial begin
        step(6);
        rst = 1'b0;
        step(4);
        repeat (8) begin
            r = rnd();
            cell_alarm = r[2:0];
            alarm_share_select = r[3];
            step(6);
            note({3'h2, r[3] ? r[2:0] : {3{|r[2:0]}}});
        end
        cell_alarm = 3'h7;
        // Host drives the bottom enable only.
        enable_in = 1'b0;
        step(4);
        note(6'h20);
        enable_in = 1'b1;
        cell_alarm = 3'h0;
        step(4);
        note(6'h10);
        test_in = 1'b1;
        step(10);
        enable_in = 1'b0;
        step(4);
        note(6'h20);
        test_in = 1'b0;
        enable_in = 1'b1;
        step(8);
        for (int d = 0; d < 7; d++) begin
            run_test(3'(d), 1'b1, 1'b1, 1'b0, 3'h0, 0, 1'b0, 3'h0);
        end
        run_test(3'h0, 1'b1, 1'b1, 1'b1, 3'h2, 0, 1'b0, 3'h2);
        run_test(3'h0, 1'b1, 1'b1, 1'b0, 3'h2, 0, 1'b0, 3'h7);
        run_test(3'h1, 1'b0, 1'b1, 1'b0, 3'h0, 0, 1'b1, 3'h0);
        run_test(3'h0, 1'b0, 1'b0, 1'b0, 3'h0, 0, 1'b0, 3'h7);
        run_test(3'h0, 1'b1, 1'b1, 1'b0, 3'h0, 4, 1'b0, 3'h7);
        run_test(3'h1, 1'b1, 1'b1, 1'b0, 3'h0, 4, 1'b0, 3'h7);
        run_test(3'h1, 1'b1, 1'b1, 1'b0, 3'h0, 0, 1'b0, 3'h0);
        summarize();
    end
endmodule
`default_nettype wire
